// ===== hw/cgc_regs.svh
`ifndef CGC_REGS_SVH
`define CGC_REGS_SVH
// register map, byte addresses on the serial port
`define CGC_NREG         36
`define CGC_REG_CTRL     6'h00
`define CGC_REG_TRIM     6'h01
`define CGC_REG_DIV_BASE 6'h04
`define CGC_DIV_STRIDE   6'h08
// byte offsets inside one divider block
`define CGC_DIV_INT_LO   0
`define CGC_DIV_INT_HI   1
`define CGC_DIV_FRAC0    2
`define CGC_DIV_FRAC1    3
`define CGC_DIV_FRAC2    4
`define CGC_DIV_MODE     5
`define CGC_DIV_SSC_AMT  6
`define CGC_DIV_SSC_STEP 7
// field positions
`define CGC_CTRL_SYNC    0
`define CGC_CTRL_BUSY    1
`define CGC_CTRL_STORED  7
`define CGC_MODE_FRAC    0
`define CGC_MODE_BYPASS  1
`define CGC_MODE_CASCADE 2
`define CGC_MODE_SSC     3
`define CGC_MODE_DOWN    4
// writable bit masks, reserved bits read zero
`define CGC_CTRL_WMASK   8'h81
`define CGC_TRIM_WMASK   8'h3F
`define CGC_NIB_WMASK    8'h0F
`define CGC_MODE_WMASK   8'h1F
// trim step, femtofarads per code
`define CGC_TRIM_STEP_FF 430
// timing
`define CGC_CLK_PERIOD_NS 4
`define CGC_SYNC_CYC     3'h4
`define CGC_STRAP_WAIT   3'h2
`define CGC_SSC_MIN_KHZ  30
`define CGC_SSC_MAX_KHZ  63
`define CGC_TRI_STEPS    64
`define CGC_SSC_STEP_MAX (1000000 / (`CGC_SSC_MIN_KHZ * `CGC_TRI_STEPS * `CGC_CLK_PERIOD_NS))
`define CGC_SSC_DIV_MIN  (`CGC_SSC_MAX_KHZ * `CGC_TRI_STEPS * `CGC_CLK_PERIOD_NS)
`define CGC_SSC_STEP_MIN ((1000000 + `CGC_SSC_DIV_MIN - 1) / `CGC_SSC_DIV_MIN)
// spread weight: 41/2^14 is 0.25 percent per amount code
`define CGC_SSC_WEIGHT   48'h29
`endif

// ===== hw/cgc_pkg.sv
package cgc_pkg;
  typedef enum logic [1:0] {
    CGC_ST_STRAP = 2'b00,
    CGC_ST_LOAD  = 2'b01,
    CGC_ST_SYNC  = 2'b11,
    CGC_ST_RUN   = 2'b10
  } cgc_state_t;
  // one serial byte write
  typedef struct packed {
    logic       valid;
    logic [5:0] addr;
    logic [7:0] data;
  } cgc_wr_t;
  // decoded divider settings
  typedef struct packed {
    logic [11:0] int_div;
    logic [23:0] frac;
    logic        frac_en;
    logic        bypass;
    logic        cascade;
    logic        ssc_en;
    logic        ssc_down;
    logic [3:0]  ssc_amt;
    logic [7:0]  ssc_step;
  } cgc_div_cfg_t;
endpackage

// ===== hw/cgc_clock_ctrl.sv
`timescale 1ns/1ps
`include "cgc_regs.svh"
// Notes on behaviour
// - strap low at power-on gives software mode, serial writes allowed except during load and sync.
// - strap high gives select mode: serial access refused, stored config loaded.
// - select pins 00,01,10,11 pick stored configs 0,1,2,3.
// - select pins held steady at power-on; that config is loaded at start.
// - software mode loads serial defaults if stored-load bit set, else config 0.
// - six-bit crystal trim, 0.43pF per code, 0 to 27.09pF.
// - four dividers, each a 12-bit integer and 24-bit fractional counter.
// - integer-only mode or fractional mode per divider.
// - per-divider triangle spread in fractional mode, at about 15 to 31kHz, output-frequency independent.
// - spread 0.25 to 4 percent center or 0.5 to 8 percent down.
// - bypass divides by 1, copying reference or another divider.
// - cascade takes input from the previous divider's output.
// - a common sync pulse resets all dividers together.
// - select mode syncs dividers at power-on and on each select change.
// - software mode has a serial control that fires divider sync.
// - dividers align on falling edges after sync.
// - block write data staged, committed together on stop.
module cgc_clock_ctrl
  import cgc_pkg::*;
#(
  parameter int NDIV = 4,
  // images 0..3 stored configs, image 4 serial defaults
  parameter logic [4:0][`CGC_NREG*8-1:0] IMG = '0
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            mode_strap_pin_i,
  input  wire logic            config_select_low_i,
  input  wire logic            config_select_high_i,
  input  wire logic            ref_tick_i,
  input  wire cgc_wr_t         wr_i,
  input  wire logic            stop_i,
  input  wire logic [5:0]      rd_addr_i,
  output logic [7:0]           rd_data_o,
  output logic                 wr_ack_o,
  output logic                 sw_mode_o,
  output logic [1:0]           cfg_index_o,
  output logic [5:0]           crystal_load_trim_o,
  output logic                 div_sync_o,
  output logic [NDIV-1:0]      div_clk_o
);

  localparam int NREG = `CGC_NREG;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers, only the second stage reads the first
  logic       strap_s1_r, strap_s2_r;
  logic [1:0] sel_s1_r, sel_s2_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
      sel_s1_r   <= 2'b00;
      sel_s2_r   <= 2'b00;
    end else begin
      strap_s1_r <= mode_strap_pin_i;
      strap_s2_r <= strap_s1_r;
      sel_s1_r   <= {config_select_high_i, config_select_low_i};
      sel_s2_r   <= sel_s1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // write mask per address, keeps reserved bits at zero
  function automatic logic [7:0] wmask(input logic [5:0] a);
    logic [2:0] o;
    o = 3'(a - `CGC_REG_DIV_BASE);
    if (a == `CGC_REG_CTRL) begin
      wmask = `CGC_CTRL_WMASK;
    end else if (a == `CGC_REG_TRIM) begin
      wmask = `CGC_TRIM_WMASK;
    end else if (a < `CGC_REG_DIV_BASE) begin
      wmask = 8'h00;
    end else if (o == 3'(`CGC_DIV_MODE)) begin
      wmask = `CGC_MODE_WMASK;
    end else if (o == 3'(`CGC_DIV_INT_HI) || o == 3'(`CGC_DIV_SSC_AMT)) begin
      wmask = `CGC_NIB_WMASK;
    end else begin
      wmask = 8'hFF;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // control state, register file and serial staging
  cgc_state_t      st_r, st_nxt;
  logic [2:0]      cnt_r, cnt_nxt;
  logic            sw_mode_r, sw_nxt;
  logic [1:0]      cfg_r, cfg_nxt;
  logic            sync_r, in_sync;
  logic            ack_r, ack_nxt;
  logic [7:0]      rd_r, rd_nxt;
  logic [7:0]      regs_r [NREG];
  logic [7:0]      regs_nxt [NREG];
  logic [7:0]      shad_r [NREG];
  logic [7:0]      shad_nxt [NREG];
  logic [NREG-1:0] pend_r, pend_nxt;
  logic [2:0]      ld_idx;
  logic            trig;

  assign in_sync = (st_r == CGC_ST_LOAD) || (st_r == CGC_ST_SYNC);

  // image choice: select mode uses the pins, software mode the stored bit
  always_comb begin
    if (!sw_mode_r) begin
      ld_idx = {1'b0, cfg_r};
    end else if (IMG[0][`CGC_CTRL_STORED]) begin
      ld_idx = 3'h4;
    end else begin
      ld_idx = 3'h0;
    end
  end

  // sequencer, staging and commit
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    sw_nxt   = sw_mode_r;
    cfg_nxt  = cfg_r;
    ack_nxt  = 1'b0;
    trig     = 1'b0;
    regs_nxt = regs_r;
    shad_nxt = shad_r;
    pend_nxt = pend_r;
    case (st_r)
      CGC_ST_STRAP: begin
        // strap caught once, after the synchroniser has filled
        if (cnt_r == `CGC_STRAP_WAIT) begin
          sw_nxt  = ~strap_s2_r;
          cfg_nxt = strap_s2_r ? sel_s2_r : 2'b00;
          cnt_nxt = 3'h0;
          st_nxt  = CGC_ST_LOAD;
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      CGC_ST_LOAD: begin
        // whole image in one cycle, before sync can drop
        for (int b = 0; b < NREG; b++) begin
          regs_nxt[b] = IMG[ld_idx][b*8 +: 8] & wmask(6'(b));
        end
        pend_nxt = '0;
        cnt_nxt  = 3'h0;
        st_nxt   = CGC_ST_SYNC;
      end
      CGC_ST_SYNC: begin
        if (cnt_r == `CGC_SYNC_CYC - 3'h1) begin
          st_nxt = CGC_ST_RUN;
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      default: begin
        if (!sw_mode_r) begin
          if (sel_s2_r != cfg_r) begin
            cfg_nxt = sel_s2_r;
            st_nxt  = CGC_ST_LOAD;
          end
        end else begin
          if (wr_i.valid && wr_i.addr < 6'(NREG)) begin
            shad_nxt[wr_i.addr] = wr_i.data & wmask(wr_i.addr);
            pend_nxt[wr_i.addr] = 1'b1;
            ack_nxt = 1'b1;
          end
          if (stop_i) begin
            for (int b = 0; b < NREG; b++) begin
              if (pend_nxt[b]) begin
                regs_nxt[b] = shad_nxt[b];
              end
            end
            // sync control self-clears, it only fires the pulse
            if (pend_nxt[0] && shad_nxt[0][`CGC_CTRL_SYNC]) begin
              trig = 1'b1;
              regs_nxt[0][`CGC_CTRL_SYNC] = 1'b0;
              cnt_nxt = 3'h0;
              st_nxt  = CGC_ST_SYNC;
            end
            pend_nxt = '0;
          end
        end
      end
    endcase
  end

  // readback, refused in select mode
  always_comb begin
    rd_nxt = 8'h00;
    if (sw_mode_r && rd_addr_i < 6'(NREG)) begin
      rd_nxt = regs_r[rd_addr_i];
      if (rd_addr_i == `CGC_REG_CTRL) begin
        rd_nxt[`CGC_CTRL_BUSY] = sync_r;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r      <= CGC_ST_STRAP;
      cnt_r     <= 3'h0;
      sw_mode_r <= 1'b0;
      cfg_r     <= 2'b00;
      sync_r    <= 1'b0;
      ack_r     <= 1'b0;
      rd_r      <= 8'h00;
      regs_r    <= '{default: 8'h00};
      shad_r    <= '{default: 8'h00};
      pend_r    <= '0;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      sw_mode_r <= sw_nxt;
      cfg_r     <= cfg_nxt;
      sync_r    <= in_sync;
      ack_r     <= ack_nxt;
      rd_r      <= rd_nxt;
      regs_r    <= regs_nxt;
      shad_r    <= shad_nxt;
      pend_r    <= pend_nxt;
    end
  end

  assign rd_data_o           = rd_r;
  assign wr_ack_o            = ack_r;
  assign sw_mode_o           = sw_mode_r;
  assign cfg_index_o         = cfg_r;
  assign div_sync_o          = sync_r;
  assign crystal_load_trim_o = regs_r[`CGC_REG_TRIM][5:0];

  //////////////////////////////////////////////////////////////////////
  // fractional output dividers
  logic [NDIV-1:0] out_r, tgl_r;
  localparam logic [7:0] STEP_MAX = 8'(`CGC_SSC_STEP_MAX);
  localparam logic [7:0] STEP_MIN = 8'(`CGC_SSC_STEP_MIN);

  for (genvar k = 0; k < NDIV; k++) begin : g_div
    localparam int B = int'(`CGC_REG_DIV_BASE) + k * int'(`CGC_DIV_STRIDE);
    cgc_div_cfg_t c;
    logic         src;
    logic [35:0]  div36;
    logic [47:0]  prod;
    logic [33:0]  peak;
    logic [39:0]  spr;
    logic [36:0]  eff;
    logic [12:0]  lim;
    logic [7:0]   stp_lim;
    logic [11:0]  cnt_r, cnt_nxt;
    logic [23:0]  acc_r, acc_nxt;
    logic         ext_r, ext_nxt;
    logic         out_nxt, tgl_nxt;
    logic         div_r, tog_r;
    logic [5:0]   tri_r, tri_nxt;
    logic         dir_r, dir_nxt;
    logic [7:0]   stp_r, stp_nxt;

    assign c.int_div  = {regs_r[B+`CGC_DIV_INT_HI][3:0], regs_r[B]};
    assign c.frac     = {regs_r[B+`CGC_DIV_FRAC2], regs_r[B+`CGC_DIV_FRAC1], regs_r[B+`CGC_DIV_FRAC0]};
    assign c.frac_en  = regs_r[B+`CGC_DIV_MODE][`CGC_MODE_FRAC];
    assign c.bypass   = regs_r[B+`CGC_DIV_MODE][`CGC_MODE_BYPASS];
    assign c.cascade  = regs_r[B+`CGC_DIV_MODE][`CGC_MODE_CASCADE];
    assign c.ssc_en   = regs_r[B+`CGC_DIV_MODE][`CGC_MODE_SSC];
    assign c.ssc_down = regs_r[B+`CGC_DIV_MODE][`CGC_MODE_DOWN];
    assign c.ssc_amt  = regs_r[B+`CGC_DIV_SSC_AMT][3:0];
    assign c.ssc_step = regs_r[B+`CGC_DIV_SSC_STEP];

    // each divider owns one bit of the shared vectors, one driver per bit
    assign out_r[k] = div_r;
    assign tgl_r[k] = tog_r;

    // first divider has no neighbour to cascade from
    if (k == 0) begin : g_first
      assign src = ref_tick_i;
    end else begin : g_casc
      assign src = c.cascade ? tgl_r[k-1] : ref_tick_i;
    end

    // ratio with spread; triangle 0..63 sweeps 0..2x peak
    always_comb begin
      div36 = {c.int_div, c.frac_en ? c.frac : 24'h0};
      prod  = 48'(div36) * (48'(c.ssc_amt) + 48'h1) * `CGC_SSC_WEIGHT;
      peak  = prod[47:14];
      spr   = 40'(peak) * 40'(tri_r);
      if (c.ssc_en && c.frac_en) begin
        // down spread only lengthens, center spreads both ways
        eff = 37'(div36) + 37'(spr[39:5]) - (c.ssc_down ? 37'h0 : 37'(peak));
      end else begin
        eff = 37'(div36);
      end
      lim = {1'b0, eff[35:24]} + 13'(ext_r);
      if (c.ssc_step > STEP_MAX) begin
        stp_lim = STEP_MAX;
      end else if (c.ssc_step < STEP_MIN) begin
        stp_lim = STEP_MIN;
      end else begin
        stp_lim = c.ssc_step;
      end
    end

    // counting, fraction carry and triangle; sync parks all high
    always_comb begin
      cnt_nxt = cnt_r;
      acc_nxt = acc_r;
      ext_nxt = ext_r;
      out_nxt = out_r[k];
      tgl_nxt = 1'b0;
      tri_nxt = tri_r;
      dir_nxt = dir_r;
      stp_nxt = stp_r;
      if (in_sync) begin
        // all outputs held high so the first edge after release falls together
        cnt_nxt = 12'h000;
        acc_nxt = 24'h00_0000;
        ext_nxt = 1'b0;
        out_nxt = 1'b1;
        tri_nxt = 6'h00;
        dir_nxt = 1'b0;
        stp_nxt = 8'h00;
      end else begin
        if (src) begin
          if (c.bypass) begin
            out_nxt = ~out_r[k];
            tgl_nxt = 1'b1;
          end else if ({1'b0, cnt_r} + 13'h1 >= lim) begin
            out_nxt = ~out_r[k];
            tgl_nxt = 1'b1;
            cnt_nxt = 12'h000;
            {ext_nxt, acc_nxt} = {1'b0, acc_r} + {1'b0, eff[23:0]};
          end else begin
            cnt_nxt = cnt_r + 12'h001;
          end
        end
        // triangle paced by the system clock, not by the output
        if (c.ssc_en) begin
          if (stp_r >= stp_lim - 8'h01) begin
            stp_nxt = 8'h00;
            if (!dir_r) begin
              dir_nxt = (tri_r == 6'h3E);
              tri_nxt = tri_r + 6'h01;
            end else begin
              dir_nxt = (tri_r != 6'h01);
              tri_nxt = tri_r - 6'h01;
            end
          end else begin
            stp_nxt = stp_r + 8'h01;
          end
        end
      end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        cnt_r    <= 12'h000;
        acc_r    <= 24'h00_0000;
        ext_r    <= 1'b0;
        div_r    <= 1'b1;
        tog_r    <= 1'b0;
        tri_r    <= 6'h00;
        dir_r    <= 1'b0;
        stp_r    <= 8'h00;
      end else begin
        cnt_r    <= cnt_nxt;
        acc_r    <= acc_nxt;
        ext_r    <= ext_nxt;
        div_r    <= out_nxt;
        tog_r    <= tgl_nxt;
        tri_r    <= tri_nxt;
        dir_r    <= dir_nxt;
        stp_r    <= stp_nxt;
      end
    end
  end

  assign div_clk_o = out_r;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_refuse;
    !sw_mode_o |-> !wr_ack_o && rd_data_o == 8'h00;
  endproperty
  a_refuse: assert property (p_refuse) else $error("serial access in select mode");

  property p_sel_map;
    st_r == CGC_ST_RUN && !sw_mode_o && sel_s2_r != cfg_r
      |=> cfg_index_o == $past(sel_s2_r) && st_r == CGC_ST_LOAD;
  endproperty
  a_sel_map: assert property (p_sel_map) else $error("select change not loaded");

  property p_mode_fixed;
    st_r != CGC_ST_STRAP && $past(st_r) != CGC_ST_STRAP |-> $stable(sw_mode_o);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("mode changed after capture");

  property p_load_img;
    st_r == CGC_ST_LOAD |=> crystal_load_trim_o == $past(IMG[ld_idx][13:8]);
  endproperty
  a_load_img: assert property (p_load_img) else $error("wrong image loaded");

  property p_sync_hold;
    st_r == CGC_ST_LOAD |=> div_sync_o [*5];
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync too short after load");

  property p_commit;
    st_r == CGC_ST_RUN && !stop_i |=> $stable(crystal_load_trim_o);
  endproperty
  a_commit: assert property (p_commit) else $error("register changed before stop");

  sequence s_realign;
    st_r == CGC_ST_SYNC ##1 div_sync_o;
  endsequence
  property p_trig;
    trig |=> s_realign;
  endproperty
  a_trig: assert property (p_trig) else $error("sync control ignored");

  property p_aligned;
    div_sync_o |-> div_clk_o == '1;
  endproperty
  a_aligned: assert property (p_aligned) else $error("dividers not parked in sync");

endmodule

// ===== bench/cgc_board_model.sv
`timescale 1ns/1ps
// board side: strap resistor and digital select drivers
module cgc_board_model #(
  parameter int SETTLE_CYC = 24,
  parameter int HOLD_CYC   = 16
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       strap_lvl_i,
  input  wire logic [1:0] sel_want_i,
  output logic            mode_strap_pin_o,
  output logic            config_select_low_o,
  output logic            config_select_high_o,
  output logic            settled_o
);
  logic [1:0] sel_r;
  int         cnt_r;

  // strap is a fixed board level, passed straight through
  assign mode_strap_pin_o     = strap_lvl_i;
  assign config_select_low_o  = sel_r[0];
  assign config_select_high_o = sel_r[1];
  assign settled_o            = (cnt_r == 0) && (sel_r == sel_want_i);

  // pins steady through reset, then one pin per step with a quiet hold after it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_r <= sel_want_i;
      cnt_r <= SETTLE_CYC;
    end else if (cnt_r != 0) begin
      cnt_r <= cnt_r - 1;
    end else if (sel_r[0] != sel_want_i[0]) begin
      sel_r[0] <= sel_want_i[0];
      cnt_r    <= HOLD_CYC;
    end else if (sel_r[1] != sel_want_i[1]) begin
      sel_r[1] <= sel_want_i[1];
      cnt_r    <= HOLD_CYC;
    end
  end
endmodule

// ===== bench/tb_cgc_clock_ctrl.sv
`timescale 1ns/1ps
`include "cgc_regs.svh"
module tb_cgc_clock_ctrl
  import cgc_pkg::*;
;
  typedef logic [4:0][`CGC_NREG*8-1:0] cgc_img_t;

  // images differ only in trim; image 0 carries the stored-load bit
  function automatic cgc_img_t mk_img();
    cgc_img_t m;
    m = '0;
    for (int k = 0; k < 5; k++) begin
      m[k][15:8] = 8'h11 + k[7:0];
    end
    m[0][7:0] = 8'h80;
    return m;
  endfunction
  localparam cgc_img_t IMG_T = mk_img();

  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       strap_lvl = 1'b0;
  logic [1:0] sel_want = 2'b00;
  logic       strap_pin, sel_lo, sel_hi, settled;
  logic       ref_tick = 1'b1;
  cgc_wr_t    wr = '0;
  logic       stop = 1'b0;
  logic [5:0] rd_addr = 6'h00;
  logic [7:0] rd_data;
  logic       wr_ack, sw_mode, div_sync;
  logic [1:0] cfg_index;
  logic [5:0] trim;
  logic [3:0] div_clk;
  int         num_errors = 0;
  int         n_tests = 0;

  always #2 clk_i = ~clk_i;

  cgc_board_model i_cgc_board_model (
    .clk_i(clk_i), .rst_i(rst_i), .strap_lvl_i(strap_lvl), .sel_want_i(sel_want),
    .mode_strap_pin_o(strap_pin), .config_select_low_o(sel_lo),
    .config_select_high_o(sel_hi), .settled_o(settled)
  );

  cgc_clock_ctrl #(.NDIV(4), .IMG(IMG_T)) i_cgc_clock_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .mode_strap_pin_i(strap_pin),
    .config_select_low_i(sel_lo), .config_select_high_i(sel_hi),
    .ref_tick_i(ref_tick), .wr_i(wr), .stop_i(stop), .rd_addr_i(rd_addr),
    .rd_data_o(rd_data), .wr_ack_o(wr_ack), .sw_mode_o(sw_mode),
    .cfg_index_o(cfg_index), .crystal_load_trim_o(trim),
    .div_sync_o(div_sync), .div_clk_o(div_clk)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // one serial byte; ack lands the cycle after the taking edge
  // an idle edge follows, so valid never rises in the step that lowered it
  task automatic wr_byte(input logic [5:0] a, input logic [7:0] d, input logic exp_ack);
    wr = '{valid: 1'b1, addr: a, data: d};
    step(1);
    wr = '0;
    chk("write ack", wr_ack, exp_ack);
    step(1);
  endtask

  task automatic commit();
    stop = 1'b1;
    step(1);
    stop = 1'b0;
    step(1);
  endtask

  task automatic rd_byte(input logic [5:0] a, output logic [7:0] d);
    rd_addr = a;
    step(1);
    d = rd_data;
  endtask

  // bounded wait for a sync pulse, counting its length and checking parked outputs
  task automatic sync_len(output int len);
    int n;
    n   = 0;
    len = 0;
    while (div_sync !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    while (div_sync === 1'b1 && len < 50) begin
      chk("outputs parked", div_clk, 4'hF);
      step(1);
      len++;
    end
  endtask

  // cycles between two successive edges of one divider output
  task automatic meas(input int k, input int exp);
    logic prev;
    int   n;
    for (int e = 0; e < 2; e++) begin
      prev = div_clk[k];
      n    = 0;
      while (div_clk[k] === prev && n < 50) begin
        step(1);
        n++;
      end
    end
    chk("divider period", n, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_sw_startup();
    logic [7:0] d;
    chk("software mode", sw_mode, 1'b1);
    chk("config index", cfg_index, 2'd0);
    chk("trim at power-up", trim, IMG_T[4][13:8]);
    rd_byte(`CGC_REG_TRIM, d);
    chk("trim readback", d, {2'b00, IMG_T[4][13:8]});
    $display("test sw_startup done");
  endtask

  task automatic t_commit();
    logic [7:0] d;
    wr_byte(`CGC_REG_TRIM, 8'h2A, 1'b1);
    wr_byte(6'h24, 8'h01, 1'b0);
    chk("staged trim hidden", trim, IMG_T[4][13:8]);
    wr_byte(`CGC_REG_TRIM, 8'hFF, 1'b1);
    commit();
    chk("committed trim", trim, 6'h3F);
    rd_byte(`CGC_REG_TRIM, d);
    chk("trim masked readback", d, 8'h3F);
    $display("test commit done");
  endtask

  // program three dividers and the sync trigger in one block write
  task automatic t_sync_divs();
    logic [7:0] d;
    int         len;
    wr_byte(`CGC_REG_DIV_BASE + `CGC_DIV_INT_LO, 8'h03, 1'b1);
    wr_byte(6'h11, 8'h02, 1'b1);
    wr_byte(6'h14, 8'h02, 1'b1);
    wr_byte(6'h19, 8'h04, 1'b1);
    wr_byte(`CGC_REG_CTRL, 8'h01, 1'b1);
    commit();
    sync_len(len);
    chk("sw sync length", len, 4);
    rd_byte(`CGC_REG_CTRL, d);
    chk("sync bit reads 0", d[0], 1'b0);
    meas(0, 3);
    meas(1, 1);
    meas(2, 2);
    $display("test sync_divs done");
  endtask

  // down spread on divider 0: half periods only stretch, by one tick at most
  task automatic t_spread();
    logic prev;
    int   len;
    int   run;
    int   lo;
    int   hi;
    int   edges;
    wr_byte(`CGC_REG_DIV_BASE + `CGC_DIV_MODE, 8'h19, 1'b1);
    wr_byte(`CGC_REG_DIV_BASE + `CGC_DIV_SSC_AMT, 8'h09, 1'b1);
    wr_byte(`CGC_REG_CTRL, 8'h01, 1'b1);
    commit();
    sync_len(len);
    chk("spread sync length", len, 4);
    run   = 0;
    lo    = 99;
    hi    = 0;
    edges = 0;
    // the first run began inside the parked phase, so it is left out
    for (int i = 0; i < 3000; i++) begin
      prev = div_clk[0];
      step(1);
      run++;
      if (div_clk[0] !== prev) begin
        if (edges > 0 && run < lo) begin
          lo = run;
        end
        if (edges > 0 && run > hi) begin
          hi = run;
        end
        edges++;
        run = 0;
      end
    end
    chk("shortest spread half period", lo, 3);
    chk("longest spread half period", hi, 4);
    $display("test spread done");
  endtask

  task automatic t_strap_fixed();
    strap_lvl = 1'b1;
    step(10);
    chk("mode held", sw_mode, 1'b1);
    wr_byte(`CGC_REG_TRIM, 8'h05, 1'b1);
    commit();
    chk("trim after strap flip", trim, 6'h05);
    strap_lvl = 1'b0;
    $display("test strap_fixed done");
  endtask

  task automatic t_sel_mode();
    logic [7:0] d;
    logic [1:0] seq [4] = '{2'b11, 2'b01, 2'b00, 2'b10};
    int         len;
    int         n;
    rst_i     = 1'b1;
    strap_lvl = 1'b1;
    sel_want  = 2'b10;
    step(5);
    rst_i = 1'b0;
    step(12);
    chk("select mode", sw_mode, 1'b0);
    chk("por config", cfg_index, 2'd2);
    chk("por trim", trim, IMG_T[2][13:8]);
    wr_byte(`CGC_REG_TRIM, 8'h01, 1'b0);
    rd_byte(`CGC_REG_TRIM, d);
    chk("read refused", d, 8'h00);
    for (int i = 0; i < 4; i++) begin
      sel_want = seq[i];
      sync_len(len);
      chk("select sync length", len, 5);
      chk("config after switch", cfg_index, seq[i]);
      chk("trim after switch", trim, IMG_T[seq[i]][13:8]);
      n = 0;
      while (settled !== 1'b1 && n < 100) begin
        step(1);
        n++;
      end
    end
    $display("test sel_mode done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    step(5);
    rst_i = 1'b0;
    step(12);
    t_sw_startup();
    t_commit();
    t_sync_divs();
    t_spread();
    t_strap_fixed();
    t_sel_mode();
    report_and_stop();
  end

  // the run needs a few thousand cycles; this cuts a hang well past that
  initial begin
    #40000;
    num_errors++;
    report_and_stop();
  end
endmodule
